// ---- core/afp_prot_top.sv ----
// afp_prot_top.sv: fault protection controller for a four half-bridge power stage
// assumes: analog comparators arrive as synchronous levels; standard APB master
// Functional notes
// - short test runs only once after power-up, never later
// - short found: all bridges hi-z until cleared, then start switching
// - test checks ground shorts first, then rail shorts
// - during test fault output low and reset pin ignored; pulldown_o still follows the reset pin here
// - test only in bridge-tied modes, skipped in single-ended
// - warning low above 125C, released below lower threshold, unlatched
// - above 155C latch shutdown, hi-z, fault low until reset
// - supply undervoltage forces hi-z and fault low, self-recovering
// - reset low forces fault output released
// - fault/warning pin encoding of status
// - global fault stops all switching, latched until reset toggled
// - channel fault stops only affected channels
// - overload latch on long limiting or high programming resistor
// - cycle limiting toggles at half rate, unreported, self-clearing
// - missing pwm hi-z affected channels, unreported, self-clearing
// - bootstrap undervoltage turns off that high side only
// - reset low: all hi-z, weak pulldown in bridge-tied modes
// - reset rising edge restarts and clears overload
// - clip indicator on pulse skipping
//
// Local design decisions: the register offsets and the APB register port.
`include "afp_defines.svh"
`default_nettype none
module afp_prot_top #(
	parameter int NCH = 4,
	parameter int OVLD_CYCLES = `AFP_OVLD_CYCLES,
	parameter int SHORT_CYCLES = `AFP_SHORT_CYCLES
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic amp_reset_n_i,
	input wire logic short_gnd_i,
	input wire logic short_rail_i,
	input wire logic temp_warn_i,
	input wire logic temp_shut_i,
	input wire logic uv_any_i,
	input wire logic [NCH-1:0] ilim_i,
	input wire logic [NCH-1:0] roc_high_i,
	input wire logic [NCH-1:0] pwm_present_i,
	input wire logic [NCH-1:0] boot_uv_i,
	input wire logic [NCH-1:0] pwm_hi_i,
	input wire logic pulse_skip_i,
	output logic [NCH-1:0] hs_on_o,
	output logic [NCH-1:0] ls_on_o,
	output logic [NCH-1:0] pulldown_o,
	output logic fault_oe_o,
	output logic warn_oe_o,
	output logic clip_oe_o,
	output logic switching_o
);
	afp_pkg::afp_state_t state;
	afp_pkg::afp_mode_t mode;
	logic rst_q;
	logic rst_rise;
	logic rst_fall;
	logic thermal_latch;
	logic [31:0] tcnt;
	logic [NCH-1:0] flip;
	logic [NCH-1:0] ch_off;
	logic glob_off;
	logic test_busy;
	logic amp_rst_n;
	logic fault_now;
	logic apb_acc;

	afp_ch_if #(.NCH(NCH)) chif();

	// reset pin reads as the pin anded with the inverse of software's reset bit
	logic sw_rst;
	assign amp_rst_n = amp_reset_n_i & ~sw_rst;
	assign test_busy = (state == afp_pkg::AFP_ST_GND) || (state == afp_pkg::AFP_ST_RAIL) ||
		(state == afp_pkg::AFP_ST_HOLD);

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			// idle level of the pin, so no false rising edge follows power-on reset
			rst_q <= 1'b1;
		end else begin
			rst_q <= amp_rst_n;
		end
	end
	// changes on the reset pin are ignored while the short test runs
	assign rst_rise = amp_rst_n && !rst_q && !test_busy;
	assign rst_fall = !amp_rst_n && rst_q && !test_busy;

	assign chif.limit = ilim_i;
	assign chif.roc_high = roc_high_i;
	assign chif.pwm_lost = ~pwm_present_i;
	assign chif.clear = rst_rise;

	afp_ovld_mon #(.NCH(NCH), .OVLD_CYCLES(OVLD_CYCLES)) u_ovld (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.ch(chif.mon)
	);

	// start-up short test: power-on reset is the only entry, pin reset never reruns it
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state <= afp_pkg::AFP_ST_IDLE;
			tcnt <= 32'h0;
		end else begin
			case (state)
				afp_pkg::AFP_ST_IDLE: begin
					tcnt <= 32'h0;
					if (uv_any_i) begin
						state <= afp_pkg::AFP_ST_IDLE;
					end else if (mode == afp_pkg::AFP_MODE_SE) begin
						state <= afp_pkg::AFP_ST_RUN;
					end else begin
						state <= afp_pkg::AFP_ST_GND;
					end
				end
				afp_pkg::AFP_ST_GND: begin
					if (short_gnd_i) begin
						state <= afp_pkg::AFP_ST_HOLD;
					end else if (tcnt >= 32'(SHORT_CYCLES)) begin
						state <= afp_pkg::AFP_ST_RAIL;
						tcnt <= 32'h0;
					end else begin
						tcnt <= tcnt + 32'h1;
					end
				end
				afp_pkg::AFP_ST_RAIL: begin
					if (short_rail_i) begin
						state <= afp_pkg::AFP_ST_HOLD;
					end else if (tcnt >= 32'(SHORT_CYCLES)) begin
						state <= afp_pkg::AFP_ST_RUN;
					end else begin
						tcnt <= tcnt + 32'h1;
					end
				end
				afp_pkg::AFP_ST_HOLD: begin
					tcnt <= 32'h0;
					if (!short_gnd_i && !short_rail_i) begin
						state <= afp_pkg::AFP_ST_RUN;
					end
				end
				afp_pkg::AFP_ST_RUN: begin
					state <= afp_pkg::AFP_ST_RUN;
				end
				default: begin
					state <= afp_pkg::AFP_ST_IDLE;
				end
			endcase
		end
	end

	// thermal shutdown: event wins over the clear from a reset edge
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			thermal_latch <= 1'b0;
		end else if (temp_shut_i) begin
			thermal_latch <= 1'b1;
		end else if (rst_fall || (!amp_rst_n && !test_busy)) begin
			thermal_latch <= 1'b0;
		end
	end

	// missing pwm on every channel is global; otherwise per channel
	assign glob_off = thermal_latch || uv_any_i || (&(~pwm_present_i)) ||
		(state != afp_pkg::AFP_ST_RUN) || !amp_rst_n;
	assign ch_off = chif.ovld | ~pwm_present_i;
	// the overload latch clears one edge after the reset rise; masking it avoids a one-cycle fault flash
	assign fault_now = thermal_latch || uv_any_i || ((|chif.ovld) && !rst_rise);

	// cycle limiting flips the output on every clock that pwm_hi_i is high and holds it while pwm_hi_i is low
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			flip <= '0;
		end else begin
			flip <= ilim_i & (flip ^ pwm_hi_i);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_drv
			always_ff @(posedge mclk_i) begin
				if (!reset_n_i || glob_off || ch_off[g]) begin
					hs_on_o[g] <= 1'b0;
					ls_on_o[g] <= 1'b0;
				end else begin
					hs_on_o[g] <= (ilim_i[g] ? flip[g] : pwm_hi_i[g]) && !boot_uv_i[g];
					ls_on_o[g] <= ilim_i[g] ? !flip[g] : !pwm_hi_i[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			pulldown_o <= '0;
		end else begin
			pulldown_o <= {NCH{!amp_rst_n && mode != afp_pkg::AFP_MODE_SE}};
		end
	end

	// pin outputs: oe high pulls the open-drain line low
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			fault_oe_o <= 1'b1;
		end else if (test_busy) begin
			fault_oe_o <= 1'b1;
		end else if (!amp_rst_n) begin
			fault_oe_o <= 1'b0;
		end else if (state == afp_pkg::AFP_ST_IDLE) begin
			fault_oe_o <= 1'b1;
		end else begin
			fault_oe_o <= fault_now;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			warn_oe_o <= 1'b0;
			clip_oe_o <= 1'b0;
			switching_o <= 1'b0;
		end else begin
			// comparator carries its own hysteresis, nothing latched here
			warn_oe_o <= temp_warn_i || temp_shut_i;
			clip_oe_o <= pulse_skip_i;
			switching_o <= !glob_off && (ch_off != {NCH{1'b1}});
		end
	end

	// apb slave, zero wait states
	assign apb_acc = psel_i && penable_i;
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			sw_rst <= 1'b0;
			mode <= afp_pkg::AFP_MODE_BTL;
		end else if (apb_acc && pwrite_i && paddr_i == `AFP_REG_CTRL) begin
			sw_rst <= pwdata_i[`AFP_CTRL_RESET_BIT];
			// mode is a strap: taking it only before the test keeps the test decision stable
			if (state == afp_pkg::AFP_ST_IDLE) begin
				mode <= afp_pkg::afp_mode_t'(pwdata_i[`AFP_CTRL_MODE_LSB +: 2]);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
			if (psel_i && !penable_i) begin
				case (paddr_i)
					`AFP_REG_CTRL: prdata_o <= {29'h0, mode, sw_rst};
					`AFP_REG_STATUS: prdata_o <= {22'h0, state, thermal_latch, uv_any_i,
						test_busy, fault_oe_o, warn_oe_o};
					`AFP_REG_CHFAULT: prdata_o <= {24'h0, 4'(chif.ovld), 4'(~pwm_present_i)};
					default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- pkg/afp_defines.svh ----
// afp_defines.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name; clock 125 MHz
`ifndef AFP_DEFINES_SVH
`define AFP_DEFINES_SVH
`define AFP_CLK_MHZ 125
`define AFP_REG_CTRL 12'h000
`define AFP_REG_SENSE 12'h004
`define AFP_REG_STATUS 12'h008
`define AFP_REG_CHFAULT 12'h00C
`define AFP_CTRL_RESET_BIT 0
`define AFP_CTRL_MODE_LSB 1
`define AFP_CTRL_RESET_VAL 32'h0000_0000
`define AFP_SENSE_RESET_VAL 32'h0000_0000
`define AFP_OVLD_TIME_US 2600
`define AFP_OVLD_CYCLES (`AFP_OVLD_TIME_US * `AFP_CLK_MHZ)
`define AFP_SHORT_TIME_US 15000
`define AFP_SHORT_CYCLES (`AFP_SHORT_TIME_US * `AFP_CLK_MHZ)
`endif

// ---- pkg/afp_pkg.sv ----
// afp_pkg.sv: types shared by the protection block
// assumes: nothing beyond the toolchain
`default_nettype none
package afp_pkg;
	typedef enum logic [1:0] {
		AFP_MODE_BTL = 2'h0,
		AFP_MODE_PBTL = 2'h1,
		AFP_MODE_SE = 2'h2
	} afp_mode_t;
	typedef enum logic [4:0] {
		AFP_ST_GND = 5'h01,
		AFP_ST_RAIL = 5'h02,
		AFP_ST_HOLD = 5'h04,
		AFP_ST_RUN = 5'h08,
		AFP_ST_IDLE = 5'h10
	} afp_state_t;
endpackage
`default_nettype wire

// ---- pkg/afp_ch_if.sv ----
// afp_ch_if.sv: per-channel status between top and channel monitor
// assumes: one clock domain
`default_nettype none
interface afp_ch_if #(parameter int NCH = 4);
	logic [NCH-1:0] limit;
	logic [NCH-1:0] roc_high;
	logic [NCH-1:0] pwm_lost;
	logic clear;
	logic [NCH-1:0] ovld;
	modport top(output limit, output roc_high, output pwm_lost, output clear, input ovld);
	modport mon(input limit, input roc_high, input pwm_lost, input clear, output ovld);
endinterface
`default_nettype wire

// ---- core/afp_olp_mon.sv ----
// afp_olp_mon.sv: per-channel overload latch from sustained current limiting
// assumes: limit flags synchronous to mclk_i
`include "afp_defines.svh"
`default_nettype none
module afp_ovld_mon #(
	parameter int NCH = 4,
	parameter int OVLD_CYCLES = `AFP_OVLD_CYCLES
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	afp_ch_if.mon ch
);
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [31:0] cnt;
			always_ff @(posedge mclk_i) begin
				if (!reset_n_i || ch.clear || !ch.limit[g]) begin
					cnt <= 32'h0;
				end else if (cnt < 32'(OVLD_CYCLES)) begin
					cnt <= cnt + 32'h1;
				end
			end
			// latch holds until reset is toggled; new event wins over clear
			always_ff @(posedge mclk_i) begin
				if (!reset_n_i) begin
					ch.ovld[g] <= 1'b0;
				end else if (ch.roc_high[g] || cnt >= 32'(OVLD_CYCLES)) begin
					ch.ovld[g] <= 1'b1;
				end else if (ch.clear) begin
					ch.ovld[g] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- dv/afp_prot_props.sv ----
// afp_prot_props.sv: port checker for the protection block
// assumes: bound to afp_prot_top, one clock, registered outputs
`default_nettype none
module afp_prot_props #(parameter int NCH = 4) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [11:0] paddr_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic amp_reset_n_i,
	input wire logic temp_warn_i,
	input wire logic temp_shut_i,
	input wire logic uv_any_i,
	input wire logic [NCH-1:0] pwm_present_i,
	input wire logic [NCH-1:0] boot_uv_i,
	input wire logic pulse_skip_i,
	input wire logic [NCH-1:0] hs_on_o,
	input wire logic [NCH-1:0] ls_on_o,
	input wire logic fault_oe_o,
	input wire logic warn_oe_o,
	input wire logic clip_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// hot spell that has already passed must still hold the fault pin
	sequence s_shut;
		temp_shut_i && amp_reset_n_i ##1 !temp_shut_i && amp_reset_n_i ##1 amp_reset_n_i;
	endsequence
	a_shut_latch: assert property (s_shut |=> fault_oe_o) else $error("shutdown not latched");
	a_uv_hiz: assert property (uv_any_i |=> (hs_on_o | ls_on_o) == '0) else $error("uv not hi-z");
	a_uv_fault: assert property (uv_any_i && amp_reset_n_i |=> fault_oe_o) else $error("uv not flagged");
	a_warn_pin: assert property (1'h1 |=> warn_oe_o == $past(temp_warn_i || temp_shut_i)) else $error("warn pin");
	a_clip_pin: assert property (pulse_skip_i |=> clip_oe_o) else $error("clip pin");
	a_boot_hs: assert property (1'h1 |=> (hs_on_o & $past(boot_uv_i)) == '0) else $error("boot hs");
	a_pwm_hiz: assert property (1'h1 |=> ((hs_on_o | ls_on_o) & ~$past(pwm_present_i)) == '0)
		else $error("no pwm not hi-z");
	a_rst_hiz: assert property (!amp_reset_n_i ##1 !amp_reset_n_i |-> (hs_on_o | ls_on_o) == '0)
		else $error("reset not hi-z");
	a_apb_err: assert property (psel_i && penable_i && pready_o && paddr_i == 12'h004 |-> pslverr_o)
		else $error("unmapped ok");
endmodule
bind afp_prot_top afp_prot_props #(.NCH(NCH)) u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.amp_reset_n_i(amp_reset_n_i), .temp_warn_i(temp_warn_i), .temp_shut_i(temp_shut_i), .uv_any_i(uv_any_i),
	.pwm_present_i(pwm_present_i), .boot_uv_i(boot_uv_i), .pulse_skip_i(pulse_skip_i), .hs_on_o(hs_on_o),
	.ls_on_o(ls_on_o), .fault_oe_o(fault_oe_o), .warn_oe_o(warn_oe_o), .clip_oe_o(clip_oe_o));
`default_nettype wire

// ---- dv/afp_ctrl_model.sv ----
// afp_ctrl_model.sv: system controller model driving the amplifier reset pin
// assumes: fault and warning pins seen as pull-down enables, one clock
`default_nettype none
module afp_ctrl_model #(parameter int WAIT = 20) (
	input wire logic mclk_i,
	input wire logic fault_oe_i,
	input wire logic warn_oe_i,
	input wire logic toggle_i,
	output logic amp_reset_n_o = 1'h1
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] since = 16'hFFFF;
	logic [3:0] held = 4'h0;
	logic fault_q = 1'h0;
	always @(posedge mclk_i) begin
		fault_q <= fault_oe_i;
		if (fault_oe_i && !fault_q)
			since <= 16'h0;
		else if (since != 16'hFFFF)
			since <= since + 16'h1;
		held <= amp_reset_n_o ? 4'h0 : held + 4'h1;
		// held low a few cycles so the bench can see the forced state
		if (toggle_i)
			amp_reset_n_o <= 1'h0;
		else if (!amp_reset_n_o && held > 4'h3 && since >= 16'(WAIT) && !warn_oe_i)
			amp_reset_n_o <= 1'h1;
	end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// tb.sv: self-checking bench for the protection block
// assumes: shortened counts, controller model on the reset pin
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OLPC = 50;
	localparam int SHC = 20;
	logic clk, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, sg = 1'h0, sr = 1'h0, tw = 1'h0;
	logic ts = 1'h0, uv = 1'h1, skip = 1'h0, tog = 1'h0, rdy, err, e, amp_rn, foe, woe, coe, sw;
	logic [11:0] pa = 12'h0;
	logic [31:0] pwd = 32'h0, rd, prd;
	logic [3:0] ilim = 4'h0, roc = 4'h0, pres = 4'hF, buv = 4'h0, hs, ls, pd;
	int n_fail = 0, n_checks = 0, cyc = 0;
	afp_prot_top #(.OVLD_CYCLES(OLPC), .SHORT_CYCLES(SHC)) u_dut (.mclk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
		.pslverr_o(err), .amp_reset_n_i(amp_rn), .short_gnd_i(sg), .short_rail_i(sr), .temp_warn_i(tw),
		.temp_shut_i(ts), .uv_any_i(uv), .ilim_i(ilim), .roc_high_i(roc), .pwm_present_i(pres), .boot_uv_i(buv),
		.pwm_hi_i(4'hF), .pulse_skip_i(skip), .hs_on_o(hs), .ls_on_o(ls), .pulldown_o(pd), .fault_oe_o(foe),
		.warn_oe_o(woe), .clip_oe_o(coe), .switching_o(sw));
	afp_ctrl_model #(.WAIT(20)) u_ctrl (.mclk_i(clk), .fault_oe_i(foe), .warn_oe_i(woe), .toggle_i(tog),
		.amp_reset_n_o(amp_rn));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	task end_sim;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// a hang anywhere below ends up here as a counted mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		rd = prd;
		e = err;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task wait_sw;
		for (int i = 0; i < 400 && sw !== 1'h1; i++) @(posedge clk);
	endtask
	task power_up(input logic [1:0] mode);
		rst_n <= 1'h0;
		uv <= 1'h1;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		apb(1'h1, 12'h000, {29'h0, mode, 1'h0});
		uv <= 1'h0;
	endtask
	task rst_toggle(input logic [3:0] pdx);
		tog <= 1'h1;
		@(posedge clk);
		tog <= 1'h0;
		repeat (3) @(posedge clk);
		chk("rst fault", foe, 32'h0);
		chk("rst hiz", {hs, ls}, 32'h0);
		chk("rst pd", pd, pdx);
		for (int i = 0; i < 100 && amp_rn !== 1'h1; i++) @(posedge clk);
		wait_sw();
		chk("restart", {foe, sw}, 32'h1);
	endtask
	task t_short;
		sg <= 1'h1;
		power_up(2'h0);
		repeat (3 * SHC) @(posedge clk);
		chk("short held", {foe, sw}, 32'h2);
		sg <= 1'h0;
		wait_sw();
		chk("short pass", {foe, sw}, 32'h1);
		sr <= 1'h1;
		repeat (3 * SHC) @(posedge clk);
		chk("late short", {foe, sw}, 32'h1);
		sr <= 1'h0;
	endtask
	task t_faults;
		tw <= 1'h1;
		repeat (2) @(posedge clk);
		chk("warn only", {foe, woe}, 32'h1);
		ts <= 1'h1;
		repeat (2) @(posedge clk);
		ts <= 1'h0;
		repeat (2) @(posedge clk);
		chk("shut", {foe, woe, sw}, 32'h6);
		tw <= 1'h0;
		rst_toggle(4'hF);
		uv <= 1'h1;
		repeat (2) @(posedge clk);
		chk("uv", {foe, woe, sw}, 32'h4);
		uv <= 1'h0;
		wait_sw();
		chk("uv gone", {foe, sw}, 32'h1);
	endtask
	task t_olp;
		ilim <= 4'h2;
		repeat (OLPC / 2) @(posedge clk);
		ilim <= 4'h0;
		@(posedge clk);
		chk("short limit", foe, 32'h0);
		ilim <= 4'h2;
		repeat (OLPC + 5) @(posedge clk);
		ilim <= 4'h0;
		@(posedge clk);
		chk("overload", {foe, hs[1], hs[3:2]}, 32'hB);
		apb(1'h0, 12'h00C, 32'h0);
		chk("chfault", rd, 32'h20);
		rst_toggle(4'hF);
		roc <= 4'h8;
		repeat (3) @(posedge clk);
		roc <= 4'h0;
		chk("roc", {foe, hs[3]}, 32'h2);
		rst_toggle(4'hF);
	endtask
	task t_misc;
		buv <= 4'h4;
		pres <= 4'hE;
		skip <= 1'h1;
		repeat (3) @(posedge clk);
		chk("unreported", {foe, coe}, 32'h1);
		buv <= 4'h0;
		pres <= 4'hF;
		skip <= 1'h0;
		apb(1'h0, 12'h004, 32'h0);
		chk("unmapped", e, 32'h1);
	endtask
	task t_se;
		sg <= 1'h1;
		power_up(2'h2);
		repeat (SHC) @(posedge clk);
		chk("se no test", sw, 32'h1);
		sg <= 1'h0;
		rst_toggle(4'h0);
	endtask
	// rail short only: ground step runs first and passes, rail step then holds
	task t_pbtl;
		sr <= 1'h1;
		power_up(2'h1);
		apb(1'h0, 12'h008, 32'h0);
		chk("gnd step", rd, 32'h26);
		repeat (3 * SHC) @(posedge clk);
		apb(1'h0, 12'h008, 32'h0);
		chk("rail short", rd, 32'h86);
		sr <= 1'h0;
		wait_sw();
		chk("pbtl pass", {foe, sw}, 32'h1);
		rst_toggle(4'hF);
	endtask
	initial begin
		t_short();
		t_faults();
		t_olp();
		t_misc();
		t_se();
		t_pbtl();
		end_sim();
	end
endmodule
`default_nettype wire
